// File: design/scg_clkgen_top.sv
// Summary of operation
// - Reset restores defaults, then relocks before lock
// - Freeze after lock holds period and runs free
// - Output frequency is reference times M over D
// - M and D set by default or serially
// - Second output is inverted synthesised clock
// - Divided output is synth over set factor
// - Lock low while invalid, high when ready
// - Lock falling means lost or new ratio; controller resets
// - Startup lock-wait stalls until locked
// - Status bit two flags stopped outputs
// - Status bit one has no function
// - Other status bits reserved, read zero
// - Done low from reset until a word ends, and while busy
// - Done high when programming finished
// - Enable low blocks reprogramming
`default_nettype none
module scg_clkgen_top
#(
   parameter int LOCK_MATCHES = scg_pkg::SCG_LOCK_MATCHES,
   parameter int REF_LOST_CYCLES = scg_pkg::SCG_REF_LOST_CYCLES,
   parameter int STOP_CYCLES = scg_pkg::SCG_STOP_CYCLES
)
(
   input wire logic clock_in,
   input wire logic sys_rst_in,
   input wire logic ref_clk_in,
   input wire logic gen_rst_in,
   input wire logic freeze_free_run_in,
   input wire logic global_tristate_ctrl_in,
   input wire logic startup_lock_wait_cycle_in,
   input wire logic prog_clock_in,
   input wire logic prog_enable_in,
   input wire logic prog_serial_in,
   input wire logic [3:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   output logic synth_clk_out,
   output logic synth_clk_out_inv,
   output logic synth_clk_div_out,
   output logic locked_out,
   output logic [7:0] status_out,
   output logic prog_complete_out,
   output logic startup_stall_out
);
   import scg_pkg::*;

   localparam int PW = SCG_PERIOD_W;

   // Half of the divided-output factor, in synth rising edges, minus one
   function automatic logic [4:0] half_count(input logic [2:0] code);
      logic [2:0] c;
      c = (code == 3'h0 || code > SCG_DIVCODE_MAX) ? 3'h1 : code;
      return 5'((6'h1 << (c - 3'h1)) - 6'h1);
   endfunction

   logic gen_rst;
   logic ref_prev_q;
   logic ref_rise;
   logic seen_q;
   logic [PW-1:0] cnt_q;
   logic [PW-1:0] period_q;
   logic period_valid_q;
   logic [3:0] match_q;
   logic ref_lost;
   scg_lock_state_t state_q;
   scg_ratio_t ratio;
   logic apply;
   logic prog_done;
   logic nco_clk;
   logic nco_toggle;
   logic nco_prev_q;
   logic [4:0] div_cnt_q;
   logic [2:0] divcode_q;
   logic [15:0] stop_cnt_q;
   logic stopped_q;
   logic [PW-1:0] cnt_inc;
   logic close_match;
   scg_ratio_t nco_ratio_q;

   assign gen_rst = sys_rst_in | gen_rst_in;
   assign ref_rise = ref_clk_in & ~ref_prev_q;
   assign ref_lost = (cnt_q == PW'(REF_LOST_CYCLES - 1));
   assign cnt_inc = cnt_q + PW'(1);
   // One cycle either way still counts as a match: edges are sampled
   assign close_match = (cnt_inc == period_q) ||
                        (cnt_inc == period_q + PW'(1)) ||
                        (cnt_inc + PW'(1) == period_q);

   scg_prog_port u_prog
   (
      .clock_in(clock_in),
      .rst_in(gen_rst),
      .prog_clock_in(prog_clock_in),
      .prog_enable_in(prog_enable_in),
      .prog_serial_in(prog_serial_in),
      .ratio_out(ratio),
      .apply_out(apply),
      .prog_complete_out(prog_done)
   );

   scg_synth_nco #(.PERIOD_W(PW)) u_nco
   (
      .clock_in(clock_in),
      .rst_in(gen_rst),
      .enable_in(period_valid_q),
      .mult_in({1'b0, nco_ratio_q.mult_m1} + 9'h1),
      .div_in({1'b0, nco_ratio_q.div_m1} + 9'h1),
      .period_in(period_q),
      .synth_out(nco_clk),
      .toggle_out(nco_toggle)
   );

   // Running ratio waits for done, so outputs never run ahead of it
   always_ff @(posedge clock_in)
   begin
      if (gen_rst)
      begin
         nco_ratio_q.mult_m1 <= SCG_MULT_M1_RST;
         nco_ratio_q.div_m1 <= SCG_DIV_M1_RST;
      end
      else if (prog_done)
         nco_ratio_q <= ratio;
   end

   // Reference period measurement in system cycles
   always_ff @(posedge clock_in)
   begin
      if (gen_rst)
      begin
         ref_prev_q <= 1'b0;
         seen_q <= 1'b0;
         cnt_q <= '0;
         period_q <= '0;
         period_valid_q <= 1'b0;
      end
      else
      begin
         ref_prev_q <= ref_clk_in;
         if (ref_rise)
         begin
            cnt_q <= '0;
            seen_q <= 1'b1;
            // Frozen: last period is kept so the output runs free
            if (seen_q && state_q != SCG_ST_FREE)
            begin
               period_q <= cnt_inc;
               period_valid_q <= 1'b1;
            end
         end
         else if (!ref_lost)
            cnt_q <= cnt_inc;
         else if (state_q != SCG_ST_FREE)
         begin
            seen_q <= 1'b0;
            period_valid_q <= 1'b0;
         end
      end
   end

   // Consecutive matching periods before lock is claimed
   always_ff @(posedge clock_in)
   begin
      if (gen_rst || apply || (ref_lost && state_q != SCG_ST_FREE))
         match_q <= 4'h0;
      else if (ref_rise && seen_q && state_q != SCG_ST_FREE)
      begin
         if (!close_match)
            match_q <= 4'h0;
         else if (match_q != 4'(LOCK_MATCHES))
            match_q <= match_q + 4'h1;
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (gen_rst)
         state_q <= SCG_ST_ACQUIRE;
      else
      begin
         case (state_q)
            SCG_ST_ACQUIRE:
               if (match_q == 4'(LOCK_MATCHES) && !global_tristate_ctrl_in &&
                   !apply)
                  state_q <= SCG_ST_LOCK;
            SCG_ST_LOCK:
               if (apply || ref_lost)
                  state_q <= SCG_ST_ACQUIRE;
               else if (freeze_free_run_in)
                  state_q <= SCG_ST_FREE;
            SCG_ST_FREE:
               if (apply)
                  state_q <= SCG_ST_ACQUIRE;
               else if (!freeze_free_run_in)
                  state_q <= SCG_ST_LOCK;
            default:
               state_q <= SCG_ST_ACQUIRE;
         endcase
      end
   end

   // Lock drops on reset, loss while not frozen, or a new ratio; it returns once the reference matches again with tristate low
   always_ff @(posedge clock_in)
   begin
      if (gen_rst)
         locked_out <= 1'b0;
      else
         locked_out <= (state_q == SCG_ST_LOCK && !apply && !ref_lost) ||
                       (state_q == SCG_ST_FREE && !apply);
   end

   always_ff @(posedge clock_in)
   begin
      if (gen_rst)
         startup_stall_out <= 1'b0;
      else
         startup_stall_out <= startup_lock_wait_cycle_in &&
                              !(state_q == SCG_ST_LOCK ||
                                state_q == SCG_ST_FREE);
   end

   // Both clock outputs from flops of one source keep them exact inverses
   always_ff @(posedge clock_in)
   begin
      if (gen_rst)
      begin
         synth_clk_out <= 1'b0;
         synth_clk_out_inv <= 1'b1;
      end
      else
      begin
         synth_clk_out <= nco_clk;
         synth_clk_out_inv <= ~nco_clk;
      end
   end

   // Divided output counts synth rising edges; phase is not aligned
   always_ff @(posedge clock_in)
   begin
      if (gen_rst)
      begin
         nco_prev_q <= 1'b0;
         div_cnt_q <= 5'h0;
         synth_clk_div_out <= 1'b0;
      end
      else
      begin
         nco_prev_q <= nco_clk;
         if (nco_clk && !nco_prev_q)
         begin
            if (div_cnt_q >= half_count(divcode_q))
            begin
               div_cnt_q <= 5'h0;
               synth_clk_div_out <= ~synth_clk_div_out;
            end
            else
               div_cnt_q <= div_cnt_q + 5'h1;
         end
      end
   end

   // Stopped flag can be high while lock is still reported
   always_ff @(posedge clock_in)
   begin
      if (gen_rst)
      begin
         stop_cnt_q <= 16'h0;
         stopped_q <= 1'b1;
      end
      else if (nco_toggle)
      begin
         stop_cnt_q <= 16'h0;
         stopped_q <= 1'b0;
      end
      else if (stop_cnt_q == 16'(STOP_CYCLES - 1))
         stopped_q <= 1'b1;
      else
         stop_cnt_q <= stop_cnt_q + 16'h1;
   end

   always_ff @(posedge clock_in)
   begin
      if (gen_rst)
      begin
         status_out <= 8'h00;
         prog_complete_out <= 1'b0;
      end
      else
      begin
         status_out <= 8'h00;
         status_out[SCG_STATUS_STOPPED_BIT] <= stopped_q;
         prog_complete_out <= prog_done;
      end
   end

   // Register port: only system reset restores the control register default
   always_ff @(posedge clock_in)
   begin
      if (sys_rst_in)
         divcode_q <= SCG_DIVCODE_RST;
      else if (reg_wr_in && reg_addr_in == SCG_OFS_CTRL)
         divcode_q <= reg_wdata_in[SCG_CTRL_DIVCODE_LSB +: 3];
   end

   always_ff @(posedge clock_in)
   begin
      if (sys_rst_in || !reg_rd_in)
         reg_rdata_out <= 32'h0;
      else
      begin
         reg_rdata_out <= 32'h0;
         case (reg_addr_in)
            SCG_OFS_CTRL:
               reg_rdata_out[SCG_CTRL_DIVCODE_LSB +: 3] <= divcode_q;
            SCG_OFS_STATUS:
            begin
               reg_rdata_out[SCG_ST_LOCKED] <= locked_out;
               reg_rdata_out[SCG_ST_PROG_DONE] <= prog_complete_out;
               reg_rdata_out[SCG_ST_STOPPED] <= stopped_q;
               reg_rdata_out[SCG_ST_FROZEN] <= (state_q == SCG_ST_FREE);
            end
            SCG_OFS_RATIO:
            begin
               reg_rdata_out[SCG_RATIO_MULT_LSB +: 8] <= ratio.mult_m1;
               reg_rdata_out[SCG_RATIO_DIV_LSB +: 8] <= ratio.div_m1;
            end
            default:
               reg_rdata_out <= 32'h0;
         endcase
      end
   end
endmodule
`default_nettype wire

// File: design/scg_pkg.sv
`default_nettype none
package scg_pkg;
   // Register map, byte addresses on the plain register port
   localparam logic [3:0] SCG_OFS_CTRL = 4'h0;
   localparam logic [3:0] SCG_OFS_STATUS = 4'h4;
   localparam logic [3:0] SCG_OFS_RATIO = 4'h8;
   // Register field positions
   localparam int SCG_CTRL_DIVCODE_LSB = 0;
   localparam int SCG_ST_LOCKED = 0;
   localparam int SCG_ST_PROG_DONE = 1;
   localparam int SCG_ST_STOPPED = 2;
   localparam int SCG_ST_FROZEN = 3;
   localparam int SCG_RATIO_MULT_LSB = 0;
   localparam int SCG_RATIO_DIV_LSB = 8;
   localparam int SCG_STATUS_STOPPED_BIT = 2;
   // Values after reset, and the largest divider code
   localparam logic [2:0] SCG_DIVCODE_RST = 3'h1;
   localparam logic [2:0] SCG_DIVCODE_MAX = 3'h5;
   localparam logic [7:0] SCG_MULT_M1_RST = 8'h03;
   localparam logic [7:0] SCG_DIV_M1_RST = 8'h00;
   // Bit, match and cycle counts, and the period width
   localparam int SCG_PROG_WORD_BITS = 9;
   localparam int SCG_LOCK_MATCHES = 4;
   localparam int SCG_REF_LOST_CYCLES = 1024;
   localparam int SCG_STOP_CYCLES = 1024;
   localparam int SCG_PERIOD_W = 16;

   typedef struct packed
   {
      logic [7:0] div_m1;
      logic [7:0] mult_m1;
   } scg_ratio_t;

   typedef enum logic [2:0]
   {
      SCG_ST_ACQUIRE = 3'b001,
      SCG_ST_LOCK = 3'b010,
      SCG_ST_FREE = 3'b100
   } scg_lock_state_t;
endpackage
`default_nettype wire

// File: design/scg_prog_port.sv
`default_nettype none
module scg_prog_port
(
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic prog_clock_in,
   input wire logic prog_enable_in,
   input wire logic prog_serial_in,
   output scg_pkg::scg_ratio_t ratio_out,
   output logic apply_out,
   output logic prog_complete_out
);
   import scg_pkg::*;

   logic pclk_prev_q;
   logic en_prev_q;
   logic [SCG_PROG_WORD_BITS-1:0] shift_q;
   logic [3:0] count_q;
   logic pclk_rise;

   assign pclk_rise = prog_clock_in & ~pclk_prev_q;

   always_ff @(posedge clock_in)
   begin
      if (rst_in)
         pclk_prev_q <= 1'b0;
      else
         pclk_prev_q <= prog_clock_in;
   end

   // Serial word: target select bit first, then value minus one LSB first
   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         shift_q <= '0;
         count_q <= 4'h0;
         en_prev_q <= 1'b0;
      end
      else if (pclk_rise)
      begin
         en_prev_q <= prog_enable_in;
         if (prog_enable_in)
         begin
            shift_q <= {prog_serial_in, shift_q[SCG_PROG_WORD_BITS-1:1]};
            if (count_q != 4'(SCG_PROG_WORD_BITS))
               count_q <= count_q + 4'h1;
         end
         else
            count_q <= 4'h0;
      end
   end

   // Word ends on the first prog clock edge with enable low
   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         ratio_out <= '{div_m1: SCG_DIV_M1_RST, mult_m1: SCG_MULT_M1_RST};
         apply_out <= 1'b0;
      end
      else
      begin
         apply_out <= 1'b0;
         if (pclk_rise && en_prev_q && !prog_enable_in &&
             count_q == 4'(SCG_PROG_WORD_BITS))
         begin
            apply_out <= 1'b1;
            if (shift_q[0])
               ratio_out.div_m1 <= shift_q[SCG_PROG_WORD_BITS-1:1];
            else
               ratio_out.mult_m1 <= shift_q[SCG_PROG_WORD_BITS-1:1];
         end
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (rst_in)
         prog_complete_out <= 1'b0;
      else if (apply_out)
         prog_complete_out <= 1'b1;
      // A finished word wins over a new first bit in the same cycle
      else if (pclk_rise && prog_enable_in)
         prog_complete_out <= 1'b0;
   end
endmodule
`default_nettype wire

// File: design/scg_synth_nco.sv
`default_nettype none
module scg_synth_nco
#(
   parameter int PERIOD_W = 16
)
(
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic enable_in,
   input wire logic [8:0] mult_in,
   input wire logic [8:0] div_in,
   input wire logic [PERIOD_W-1:0] period_in,
   output logic synth_out,
   output logic toggle_out
);
   import scg_pkg::*;

   localparam int ACC_W = PERIOD_W + 10;
   logic [ACC_W-1:0] acc_q;
   logic [ACC_W-1:0] sum;
   logic [ACC_W-1:0] thr;

   // Half periods: toggle rate 2M/(D*P) per cycle gives f_ref*M/D
   assign thr = ACC_W'(div_in * period_in);
   assign sum = acc_q + ACC_W'({mult_in, 1'b0});

   // Above half the system clock the output saturates at one toggle a cycle
   always_ff @(posedge clock_in)
   begin
      if (rst_in || !enable_in)
      begin
         acc_q <= '0;
         synth_out <= 1'b0;
         toggle_out <= 1'b0;
      end
      else if (sum >= thr)
      begin
         acc_q <= sum - thr;
         synth_out <= ~synth_out;
         toggle_out <= 1'b1;
      end
      else
      begin
         acc_q <= sum;
         toggle_out <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// File: tb/scg_prog_model.sv
`default_nettype none
module scg_prog_model
#(
   parameter int REF_PERIOD = 16
)
(
   input wire logic clock_in,
   output logic prog_clock_out,
   output logic prog_enable_out,
   output logic prog_serial_out,
   output logic gen_rst_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      prog_clock_out = 1'b0;
      prog_enable_out = 1'b0;
      prog_serial_out = 1'b0;
      gen_rst_out = 1'b0;
   end
   // Closing edge with enable low applies the word; clock idles low
   task automatic send_word(input logic tgt, input logic [7:0] vm1,
      input int nbits);
      logic [8:0] w;
      w = {vm1, tgt};
      for (int i = 0; i <= nbits; i++)
      begin
         @(posedge clock_in);
         prog_clock_out <= 1'b0;
         prog_enable_out <= (i < nbits);
         prog_serial_out <= (i < nbits) ? w[i] : ~prog_serial_out;
         repeat (3) @(posedge clock_in);
         prog_clock_out <= 1'b1;
         repeat (3) @(posedge clock_in);
      end
      @(posedge clock_in);
      prog_clock_out <= 1'b0;
   endtask
   // Counted in system cycles so a stopped reference cannot hang it
   task automatic pulse_reset();
      @(posedge clock_in);
      gen_rst_out <= 1'b1;
      repeat (3 * REF_PERIOD) @(posedge clock_in);
      gen_rst_out <= 1'b0;
   endtask
endmodule
`default_nettype wire

// File: tb/scg_sva.sv
`default_nettype none
module scg_sva
#(
   parameter int LOCK_MATCHES = 4,
   parameter int REF_LOST_CYCLES = 1024,
   parameter int STOP_CYCLES = 1024
)
(
   input wire logic clock_in,
   input wire logic sys_rst_in,
   input wire logic ref_clk_in,
   input wire logic gen_rst_in,
   input wire logic freeze_free_run_in,
   input wire logic global_tristate_ctrl_in,
   input wire logic startup_lock_wait_cycle_in,
   input wire logic synth_clk_out,
   input wire logic synth_clk_out_inv,
   input wire logic locked_out,
   input wire logic [7:0] status_out,
   input wire logic prog_complete_out,
   input wire logic startup_stall_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_q, synth_q;
   logic [15:0] lost_q, stop_q;
   default clocking @(posedge clock_in); endclocking
   default disable iff (sys_rst_in);
   always_ff @(posedge clock_in)
   begin
      ref_q <= ref_clk_in;
      synth_q <= synth_clk_out;
   end
   // Freeze keeps lock on purpose, so it restarts the count
   always_ff @(posedge clock_in)
      if (sys_rst_in || freeze_free_run_in || ref_q != ref_clk_in)
         lost_q <= 16'h0;
      else if (lost_q != 16'hffff)
         lost_q <= lost_q + 16'h1;
   always_ff @(posedge clock_in)
      if (sys_rst_in || gen_rst_in || synth_q != synth_clk_out)
         stop_q <= 16'h0;
      else if (stop_q != 16'hffff)
         stop_q <= stop_q + 16'h1;
   property p_inv;
      synth_clk_out_inv == ~synth_clk_out;
   endproperty
   a_inv: assert property (p_inv)
      else $error("inverted clock mismatch");
   property p_rsv;
      status_out[7:3] == 5'h0 && status_out[0] == 1'b0;
   endproperty
   a_rsv: assert property (p_rsv)
      else $error("reserved status bit set");
   property p_b1;
      status_out[1] == 1'b0;
   endproperty
   a_b1: assert property (p_b1)
      else $error("status bit one set");
   property p_genrst;
      gen_rst_in |=> !locked_out && !prog_complete_out;
   endproperty
   a_genrst: assert property (p_genrst)
      else $error("generator reset ignored");
   property p_stall;
      (startup_lock_wait_cycle_in && !locked_out && !gen_rst_in)[*2]
         |-> startup_stall_out;
   endproperty
   a_stall: assert property (p_stall)
      else $error("startup not stalled");
   property p_nostall;
      !startup_lock_wait_cycle_in |=> !startup_stall_out;
   endproperty
   a_nostall: assert property (p_nostall)
      else $error("stall without request");
   property p_tri;
      global_tristate_ctrl_in && !locked_out |=> !locked_out;
   endproperty
   a_tri: assert property (p_tri)
      else $error("locked under tristate");
   property p_lost;
      lost_q > REF_LOST_CYCLES + 4 |-> !locked_out;
   endproperty
   a_lost: assert property (p_lost)
      else $error("lock kept without reference");
   property p_stop;
      stop_q > STOP_CYCLES + 4 |-> status_out[2];
   endproperty
   a_stop: assert property (p_stop)
      else $error("stop not flagged");
   property p_run;
      $changed(synth_clk_out) && !gen_rst_in && !$past(gen_rst_in)
         |-> ##[1:3] !status_out[2];
   endproperty
   a_run: assert property (p_run)
      else $error("stop flag while toggling");
   property p_relock;
      $rose(prog_complete_out) |-> !locked_out;
   endproperty
   a_relock: assert property (p_relock)
      else $error("lock held across new ratio");
endmodule
`default_nettype wire

// File: tb/test_scg_clkgen_top.sv
`default_nettype none
module test_scg_clkgen_top;
   timeunit 1ns;
   timeprecision 1ps;
   import scg_pkg::*;
   logic clock_in, sys_rst_in, freeze, tristate, lwait;
   logic ref_clk = 1'b0;
   logic wr_q, rd_q, ref_run, pclk, pen, pdat, grst;
   logic synth, inv, dvc, locked, done, stall;
   logic [3:0] addr;
   logic [31:0] wdata, rdata;
   logic [7:0] status;
   int failures, checks;
   int ref_cnt = 0;
   scg_clkgen_top #(.LOCK_MATCHES(2), .REF_LOST_CYCLES(64),
      .STOP_CYCLES(64)) scg_clkgen_top_i (.clock_in(clock_in),
      .sys_rst_in(sys_rst_in), .ref_clk_in(ref_clk), .gen_rst_in(grst),
      .freeze_free_run_in(freeze), .global_tristate_ctrl_in(tristate),
      .startup_lock_wait_cycle_in(lwait), .prog_clock_in(pclk),
      .prog_enable_in(pen), .prog_serial_in(pdat), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr_q), .reg_rd_in(rd_q),
      .reg_rdata_out(rdata), .synth_clk_out(synth),
      .synth_clk_out_inv(inv), .synth_clk_div_out(dvc),
      .locked_out(locked), .status_out(status),
      .prog_complete_out(done), .startup_stall_out(stall));
   scg_prog_model scg_prog_model_i (.clock_in(clock_in),
      .prog_clock_out(pclk), .prog_enable_out(pen),
      .prog_serial_out(pdat), .gen_rst_out(grst));
   initial
   begin
      clock_in = 1'b0;
      forever #12.5 clock_in = ~clock_in;
   end
   // Reference period of 16 cycles; stopping it holds the level
   always @(posedge clock_in)
      if (ref_run)
      begin
         ref_cnt <= (ref_cnt + 1) % 8;
         if (ref_cnt == 7)
            ref_clk <= ~ref_clk;
      end
   task automatic finish_test();
      if (failures == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic bad(input string m);
      failures++;
      $display("wrong value at %0t: %s", $time, m);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
         bad($sformatf("read %h expected %h", got, exp));
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      checks++;
      if (got !== exp)
         bad($sformatf("flag %b expected %b", got, exp));
   endtask
   task automatic chk_rng(input int got, input int lo, input int hi);
      checks++;
      if (got < lo || got > hi)
         bad($sformatf("count %0d outside %0d..%0d", got, lo, hi));
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock_in);
      wr_q <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clock_in);
      wr_q <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clock_in);
      rd_q <= 1'b1;
      addr <= a;
      @(posedge clock_in);
      rd_q <= 1'b0;
      #1;
      d = rdata;
   endtask
   task automatic await(input int sel, input logic v);
      int n;
      n = 0;
      while (n < 3000 && (sel == 0 ? locked : sel == 1 ? done :
         status[2]) !== v)
      begin
         @(posedge clock_in);
         #1;
         n++;
      end
      chk_rng(n, 0, 2999);
   endtask
   task automatic meas(output int fx, output int hi, output int dv);
      logic s, d;
      fx = 0;
      hi = 0;
      dv = 0;
      s = synth;
      d = dvc;
      repeat (256)
      begin
         @(posedge clock_in);
         #1;
         fx += (synth === 1'b1 && s === 1'b0);
         hi += (synth === 1'b1);
         dv += (dvc === 1'b1 && d === 1'b0);
         s = synth;
         d = dvc;
      end
   endtask
   task automatic t_regs();
      logic [31:0] d;
      rd(SCG_OFS_CTRL, d);
      chk(d, 32'h1);
      rd(SCG_OFS_RATIO, d);
      chk(d, 32'h3);
      wr(SCG_OFS_RATIO, 32'hffff);
      rd(SCG_OFS_RATIO, d);
      chk(d, 32'h3);
      rd(4'hc, d);
      chk(d, 32'h0);
      wr(SCG_OFS_CTRL, 32'h7);
      rd(SCG_OFS_CTRL, d);
      chk(d, 32'h7);
   endtask
   task automatic t_lock();
      int fx, hi, dv;
      logic [31:0] d;
      await(0, 1'b1);
      meas(fx, hi, dv);
      chk_rng(fx, 63, 65);
      chk_rng(hi, 124, 132);
      chk_rng(dv, 31, 33);
      wr(SCG_OFS_CTRL, 32'h3);
      rd(SCG_OFS_CTRL, d);
      chk(d, 32'h3);
      meas(fx, hi, dv);
      chk_rng(dv, 7, 9);
      wr(SCG_OFS_CTRL, 32'h1);
   endtask
   task automatic t_prog();
      int fx, hi, dv;
      logic [31:0] d;
      scg_prog_model_i.send_word(1'b1, 8'h02, 9);
      await(1, 1'b1);
      chk_bit(locked, 1'b0);
      rd(SCG_OFS_RATIO, d);
      chk(d, 32'h0203);
      await(0, 1'b1);
      meas(fx, hi, dv);
      chk_rng(fx, 20, 23);
      scg_prog_model_i.send_word(1'b0, 8'h07, 0);
      chk_bit(done, 1'b1);
      scg_prog_model_i.send_word(1'b0, 8'h07, 8);
      chk_bit(done, 1'b0);
      rd(SCG_OFS_RATIO, d);
      chk(d, 32'h0203);
      scg_prog_model_i.pulse_reset();
      #1;
      chk_bit(done, 1'b0);
      chk_bit(locked, 1'b0);
      rd(SCG_OFS_RATIO, d);
      chk(d, 32'h3);
      await(0, 1'b1);
   endtask
   task automatic t_tri();
      @(posedge clock_in);
      tristate <= 1'b1;
      lwait <= 1'b1;
      scg_prog_model_i.pulse_reset();
      repeat (400) @(posedge clock_in);
      #1;
      chk_bit(locked, 1'b0);
      chk_bit(stall, 1'b1);
      @(posedge clock_in);
      tristate <= 1'b0;
      await(0, 1'b1);
      repeat (2) @(posedge clock_in);
      #1;
      chk_bit(stall, 1'b0);
      lwait <= 1'b0;
   endtask
   task automatic t_freeze();
      int fx, hi, dv;
      @(posedge clock_in);
      freeze <= 1'b1;
      repeat (4) @(posedge clock_in);
      ref_run <= 1'b0;
      repeat (300) @(posedge clock_in);
      #1;
      chk_bit(locked, 1'b1);
      meas(fx, hi, dv);
      chk_rng(fx, 63, 65);
      @(posedge clock_in);
      freeze <= 1'b0;
      await(0, 1'b0);
      await(2, 1'b1);
      @(posedge clock_in);
      ref_run <= 1'b1;
      scg_prog_model_i.pulse_reset();
      await(0, 1'b1);
      await(2, 1'b0);
   endtask
   initial
   begin
      #(25 * 30000);
      failures++;
      finish_test();
   end
   initial
   begin
      {sys_rst_in, ref_run} = 2'b11;
      {freeze, tristate, lwait, wr_q, rd_q} = 5'h0;
      addr = 4'h0;
      wdata = 32'h0;
      repeat (2) @(posedge clock_in);
      sys_rst_in <= 1'b0;
      t_regs();
      t_lock();
      t_prog();
      t_tri();
      t_freeze();
      finish_test();
   end
endmodule
bind scg_clkgen_top scg_sva #(.LOCK_MATCHES(LOCK_MATCHES),
   .REF_LOST_CYCLES(REF_LOST_CYCLES), .STOP_CYCLES(STOP_CYCLES))
   scg_sva_i (.clock_in, .sys_rst_in, .ref_clk_in, .gen_rst_in,
   .freeze_free_run_in, .global_tristate_ctrl_in,
   .startup_lock_wait_cycle_in, .synth_clk_out, .synth_clk_out_inv,
   .locked_out, .status_out, .prog_complete_out, .startup_stall_out);
`default_nettype wire
